// ===== rtl/sref_pkg.sv
/*
 * sref_pkg: register map, field positions, reset values, state codes and
 * timing constants for the reference capture and multichip sync block.
 * Assumes a byte-wide register port with 12-bit addresses.
 */
package sref_pkg;
	localparam int unsigned AW = 12;
	localparam int unsigned DW = 8;

	localparam logic [11:0] OFS_INPUT_CLOCK_DIVIDER       = 12'h010b;
	localparam logic [11:0] OFS_REFERENCE_CAPTURE_CONTROL = 12'h0120;
	localparam logic [11:0] OFS_IGNORE_COUNT              = 12'h0121;
	localparam logic [11:0] OFS_REFERENCE_SKEW_WINDOW     = 12'h0122;
	localparam logic [11:0] OFS_TIMESTAMP_DELAY           = 12'h0123;
	localparam logic [11:0] OFS_SETUP_HOLD_MONITOR_STATUS = 12'h0128;
	localparam logic [11:0] OFS_TIMING_FLAGS              = 12'h0129;
	localparam logic [11:0] OFS_MULTIFRAME_LENGTH         = 12'h0130;
	localparam logic [11:0] OFS_CHIP_SYNC_MODE            = 12'h01ff;
	localparam logic [11:0] OFS_CONTROL_BIT_FUNCTION_LOW  = 12'h0559;
	localparam logic [11:0] OFS_CONTROL_BIT_FUNCTION_HIGH = 12'h055a;
	localparam logic [11:0] OFS_CONTROL_BIT_COUNT         = 12'h058f;
	localparam logic [11:0] OFS_SUBCLASS                  = 12'h0590;

	// reference_capture_control fields
	localparam int unsigned CAP_MODE_LSB   = 1;
	localparam int unsigned CAP_EDGE_BIT   = 3;
	localparam int unsigned CAP_FALL_BIT   = 4;
	localparam logic [1:0]  MODE_OFF       = 2'h0;
	localparam logic [1:0]  MODE_CONT      = 2'h1;
	localparam logic [1:0]  MODE_NSHOT     = 2'h2;
	// skew window fields
	localparam int unsigned SKEW_NEG_LSB   = 2;
	localparam int unsigned SKEW_POS_LSB   = 0;
	// control bits, sync mode and subclass bits, ignore limit and monitor constants
	localparam int unsigned CS_LSB         = 6;
	localparam int unsigned FUNC_HI_LSB    = 4;
	localparam logic [2:0]  FUNC_REF_MARK  = 3'h5;
	localparam int unsigned SUBCLASS_BIT   = 5;
	localparam int unsigned SYNC_MODE_BIT  = 0;
	localparam logic [4:0]  IGNORE_MAX     = 5'h10;
	localparam logic [3:0]  MON_NO_ERR     = 4'h8;
	localparam logic [2:0]  HOLD_SAMPLES   = 3'h4;

	localparam logic [7:0]  RST_DIVIDER    = 8'h00;
	localparam logic [7:0]  RST_CAPTURE    = 8'h00;
	localparam logic [7:0]  RST_IGNORE     = 8'h00;
	localparam logic [7:0]  RST_SKEW       = 8'h00;
	localparam logic [7:0]  RST_TS_DELAY   = 8'h00;
	localparam logic [7:0]  RST_MF_LENGTH  = 8'h1f;
	localparam logic [7:0]  RST_SYNC_MODE  = 8'h00;
	localparam logic [7:0]  RST_FUNC_LOW   = 8'h00;
	localparam logic [7:0]  RST_FUNC_HIGH  = 8'h00;
	localparam logic [7:0]  RST_CS         = 8'h00;
	localparam logic [7:0]  RST_SUBCLASS   = 8'h20;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_IGNORE = 3'b010,
		ST_ARMED  = 3'b100
	} sref_state_e;
endpackage

// ===== rtl/sref_sync.sv
/*
 * sref_sync: two-flop synchroniser for the reference pin, plus one extra
 * stage used when the alternate capture edge is selected.
 * Assumes the pin is asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module sref_sync (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic ce_i,
	input  wire logic pin_i,
	input  wire logic late_i,
	output logic      level_o
);
	typedef struct packed {
		logic meta;
		logic stable;
		logic late;
	} sref_sync_s;

	sref_sync_s st;
	sref_sync_s next_st;

	always_comb
	begin
		next_st        = st;
		next_st.meta   = pin_i;
		next_st.stable = st.meta;
		next_st.late   = st.stable;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			st <= '0;
		else if (ce_i)
			st <= next_st;
	end

	// alternate edge costs one cycle of latency; no real half-cycle sampling here
	assign level_o = late_i ? st.late : st.stable;
endmodule // sref_sync
`default_nettype wire

// ===== rtl/sref_capture.sv
/*
 * sref_capture: reference capture, arming, ignore count, skew window
 * resync, sample timestamp tagging and setup/hold monitor.
 * Assumes one clock per converter sample and a byte register port.
 */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - one mode bit picks normal sync (0, default) or timestamping (1)
// - timestamping leaves dividers alone and tags the coinciding sample
// - tagging needs capture mode continuous or N-shot; otherwise nothing tagged
// - tagging needs control-bit count of 1, 2 or 3
// - three-bit function per control bit; code 5 marks reference event
// - control bits are used from bit 2 downward
// - timestamp delay shifts which sample gets the tag
// - no tagging while decimation is in use
// - mode field 1 or 2 picks input type and arms capture; 3 leaves capture idle
// - N-shot clears the mode field after the qualifying event
// - normal mode event realigns divider, downconverters, monitor and framing
// - software picks transition polarity and capture edge; default rising both
// - N-shot ignores a programmed number of events, up to 16
// - continuous mode resyncs when edge misses the aligned multiframe phase
// - skew window suppresses resync; negative before phase zero, positive after
// - negative window at bits 3:2, positive at bits 1:0
// - status register: hold in bits 7:4, setup in bits 3:0
// - setup shows level before the edge, hold the level after
// - decode status into setup, hold or generic error flags
// - one bit selects subclass, default deterministic
module sref_capture (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        sysref_i,
	input  wire logic        decimation_ratio_mode_i,
	output logic      [7:0]  rdata_o,
	output logic             divider_sync_o,
	output logic             lmfc_o,
	output logic      [2:0]  ctrl_bits_o,
	output logic             subclass_o
);
	typedef struct packed {
		logic [7:0]          divider;
		logic [7:0]          capture;
		logic [7:0]          ignore_cnt;
		logic [7:0]          skew;
		logic [7:0]          ts_delay;
		logic [7:0]          mf_len;
		logic [7:0]          sync_mode;
		logic [7:0]          func_low;
		logic [7:0]          func_high;
		logic [7:0]          cs;
		logic [7:0]          subclass;
		logic [3:0]          setup_st;
		logic [3:0]          hold_st;
		sref_pkg::sref_state_e fsm;
		logic [4:0]          ignore_left;
		logic [7:0]          mf_phase;
		logic [3:0]          hist;
		logic [2:0]          hold_left;
		logic [7:0]          ts_left;
		logic                ts_pend;
		logic [7:0]          rdata;
		logic                div_sync;
		logic                lmfc;
		logic [2:0]          ctrl;
	} sref_cap_s;

	sref_cap_s st;
	sref_cap_s next_st;
	logic      ref_level;

	sref_sync u_sync (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.ce_i    (ce_i),
		.pin_i   (sysref_i),
		.late_i  (st.capture[sref_pkg::CAP_EDGE_BIT]),
		.level_o (ref_level)
	);

	logic [1:0] mode;
	logic       falling;
	logic       event_seen;
	logic [1:0] neg_win;
	logic [1:0] pos_win;
	logic       in_window;
	logic       ts_ok;
	logic [2:0] cb_en;
	logic [2:0] cb_mark;
	logic [2:0] cb_func [3];
	logic [7:0] ev_phase;
	logic [7:0] rd_mux;
	logic       setup_err;
	logic       hold_err;
	logic       any_err;

	// selector positions differ per control bit, so gather them before the loop
	assign cb_func[0] = st.func_low[2:0];
	assign cb_func[1] = st.func_low[sref_pkg::FUNC_HI_LSB +: 3];
	assign cb_func[2] = st.func_high[2:0];

	generate
		for (genvar gi = 0; gi < 3; gi++)
		begin : g_mark
			assign cb_mark[gi] = cb_en[gi] && (cb_func[gi] == sref_pkg::FUNC_REF_MARK);
		end
	endgenerate

	always_comb
	begin
		mode    = st.capture[sref_pkg::CAP_MODE_LSB +: 2];
		falling = st.capture[sref_pkg::CAP_FALL_BIT];
		// qualifying transition on the synchronised level
		event_seen = falling ? (st.hist[0] & ~ref_level) : (~st.hist[0] & ref_level);
		neg_win = st.skew[sref_pkg::SKEW_NEG_LSB +: 2];
		pos_win = st.skew[sref_pkg::SKEW_POS_LSB +: 2];
		// judge the phase that the capture cycle itself carries: a resync puts phase 0
		// on that cycle, so a source period of whole multiframes lands on phase 0 again
		if (st.mf_phase >= st.mf_len)
			ev_phase = 8'h00;
		else
			ev_phase = st.mf_phase + 8'h01;
		// phase 0 is aligned; low phases are late, phases near the end are early
		in_window = (ev_phase <= {6'h00, pos_win}) ||
			(ev_phase > st.mf_len - {6'h00, neg_win});
		ts_ok = st.sync_mode[sref_pkg::SYNC_MODE_BIT] && !decimation_ratio_mode_i &&
			(st.cs[sref_pkg::CS_LSB +: 2] != 2'h0);
		case (st.cs[sref_pkg::CS_LSB +: 2])
			2'h1:    cb_en = 3'b100;
			2'h2:    cb_en = 3'b110;
			2'h3:    cb_en = 3'b111;
			default: cb_en = 3'b000;
		endcase
		setup_err = (st.hold_st == 4'h0) && (st.setup_st < sref_pkg::MON_NO_ERR) &&
			(st.setup_st != 4'h0);
		hold_err  = (st.setup_st == 4'h0) && (st.hold_st > sref_pkg::MON_NO_ERR);
		any_err   = (st.setup_st == 4'h0) && (st.hold_st == 4'h0);
		case (addr_i)
			sref_pkg::OFS_INPUT_CLOCK_DIVIDER:       rd_mux = st.divider;
			sref_pkg::OFS_REFERENCE_CAPTURE_CONTROL: rd_mux = st.capture;
			sref_pkg::OFS_IGNORE_COUNT:              rd_mux = st.ignore_cnt;
			sref_pkg::OFS_REFERENCE_SKEW_WINDOW:     rd_mux = st.skew;
			sref_pkg::OFS_TIMESTAMP_DELAY:           rd_mux = st.ts_delay;
			sref_pkg::OFS_SETUP_HOLD_MONITOR_STATUS: rd_mux = {st.hold_st, st.setup_st};
			sref_pkg::OFS_TIMING_FLAGS:              rd_mux = {5'h00, any_err, hold_err, setup_err};
			sref_pkg::OFS_MULTIFRAME_LENGTH:         rd_mux = st.mf_len;
			sref_pkg::OFS_CHIP_SYNC_MODE:            rd_mux = st.sync_mode;
			sref_pkg::OFS_CONTROL_BIT_FUNCTION_LOW:  rd_mux = st.func_low;
			sref_pkg::OFS_CONTROL_BIT_FUNCTION_HIGH: rd_mux = st.func_high;
			sref_pkg::OFS_CONTROL_BIT_COUNT:         rd_mux = st.cs;
			sref_pkg::OFS_SUBCLASS:                  rd_mux = st.subclass;
			default:                                 rd_mux = 8'h00;
		endcase
	end

	always_comb
	begin
		next_st          = st;
		next_st.rdata    = rd_i ? rd_mux : 8'h00;
		next_st.div_sync = 1'b0;
		next_st.ctrl     = 3'b000;
		next_st.hist     = {st.hist[2:0], ref_level};

		// free-running multiframe phase counter
		if (st.mf_phase >= st.mf_len)
			next_st.mf_phase = 8'h00;
		else
			next_st.mf_phase = st.mf_phase + 8'h01;
		next_st.lmfc = (next_st.mf_phase == 8'h00);

		// hold side of the monitor: samples taken after the capture edge
		if (st.hold_left != 3'h0)
		begin
			next_st.hold_st   = {st.hold_st[2:0], ref_level};
			next_st.hold_left = st.hold_left - 3'h1;
		end

		// delayed timestamp tag
		if (st.ts_pend)
		begin
			if (st.ts_left == 8'h00)
			begin
				next_st.ts_pend = 1'b0;
				next_st.ctrl    = cb_mark;
			end
			else
				next_st.ts_left = st.ts_left - 8'h01;
		end

		case (st.fsm)
			sref_pkg::ST_IDLE:
			begin
				next_st.fsm = sref_pkg::ST_IDLE;
			end
			sref_pkg::ST_IGNORE:
			begin
				if (event_seen)
				begin
					next_st.ignore_left = st.ignore_left - 5'h01;
					if (st.ignore_left == 5'h01)
						next_st.fsm = sref_pkg::ST_ARMED;
				end
			end
			sref_pkg::ST_ARMED:
			begin
				if (event_seen)
				begin
					// setup side: the level history just ahead of the edge
					next_st.setup_st  = st.hist;
					next_st.hold_st   = 4'h0;
					next_st.hold_left = sref_pkg::HOLD_SAMPLES;
					if (st.sync_mode[sref_pkg::SYNC_MODE_BIT])
					begin
						if (ts_ok)
						begin
							next_st.ts_pend = 1'b1;
							next_st.ts_left = st.ts_delay;
						end
					end
					else if (mode == sref_pkg::MODE_NSHOT || !in_window)
					begin
						// realign dividers, downconverters, monitor and framing together
						next_st.div_sync = 1'b1;
						next_st.mf_phase = 8'h00;
						next_st.lmfc     = 1'b1;
					end
					if (mode == sref_pkg::MODE_NSHOT)
					begin
						next_st.capture[sref_pkg::CAP_MODE_LSB +: 2] = sref_pkg::MODE_OFF;
						next_st.fsm = sref_pkg::ST_IDLE;
					end
				end
			end
			default:
			begin
				next_st.fsm = sref_pkg::ST_IDLE;
			end
		endcase

		if (mode == sref_pkg::MODE_OFF && st.fsm != sref_pkg::ST_IDLE)
			next_st.fsm = sref_pkg::ST_IDLE;

		if (wr_i)
		begin
			case (addr_i)
				sref_pkg::OFS_INPUT_CLOCK_DIVIDER:       next_st.divider    = wdata_i;
				sref_pkg::OFS_IGNORE_COUNT:
				begin
					// clipped so the five-bit down counter can never wrap
					next_st.ignore_cnt = (wdata_i > {3'h0, sref_pkg::IGNORE_MAX}) ?
						{3'h0, sref_pkg::IGNORE_MAX} : wdata_i;
				end
				sref_pkg::OFS_REFERENCE_SKEW_WINDOW:     next_st.skew       = wdata_i;
				sref_pkg::OFS_TIMESTAMP_DELAY:           next_st.ts_delay   = wdata_i;
				sref_pkg::OFS_MULTIFRAME_LENGTH:         next_st.mf_len     = wdata_i;
				sref_pkg::OFS_CHIP_SYNC_MODE:            next_st.sync_mode  = wdata_i;
				sref_pkg::OFS_CONTROL_BIT_FUNCTION_LOW:  next_st.func_low   = wdata_i;
				sref_pkg::OFS_CONTROL_BIT_FUNCTION_HIGH: next_st.func_high  = wdata_i;
				sref_pkg::OFS_CONTROL_BIT_COUNT:         next_st.cs         = wdata_i;
				sref_pkg::OFS_SUBCLASS:                  next_st.subclass   = wdata_i;
				sref_pkg::OFS_REFERENCE_CAPTURE_CONTROL:
				begin
					// a software write beats the self-clear in the same cycle
					next_st.capture     = wdata_i;
					next_st.ignore_left = st.ignore_cnt[4:0];
					case (wdata_i[sref_pkg::CAP_MODE_LSB +: 2])
						sref_pkg::MODE_CONT:  next_st.fsm = sref_pkg::ST_ARMED;
						sref_pkg::MODE_NSHOT:
							next_st.fsm = (st.ignore_cnt[4:0] == 5'h00) ?
								sref_pkg::ST_ARMED : sref_pkg::ST_IGNORE;
						default:              next_st.fsm = sref_pkg::ST_IDLE;
					endcase
				end
				default:
				begin
					next_st.fsm = next_st.fsm;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st            <= '0;
			st.divider    <= sref_pkg::RST_DIVIDER;
			st.capture    <= sref_pkg::RST_CAPTURE;
			st.ignore_cnt <= sref_pkg::RST_IGNORE;
			st.skew       <= sref_pkg::RST_SKEW;
			st.ts_delay   <= sref_pkg::RST_TS_DELAY;
			st.mf_len     <= sref_pkg::RST_MF_LENGTH;
			st.sync_mode  <= sref_pkg::RST_SYNC_MODE;
			st.func_low   <= sref_pkg::RST_FUNC_LOW;
			st.func_high  <= sref_pkg::RST_FUNC_HIGH;
			st.cs         <= sref_pkg::RST_CS;
			st.subclass   <= sref_pkg::RST_SUBCLASS;
			st.fsm        <= sref_pkg::ST_IDLE;
		end
		else if (ce_i)
			st <= next_st;
	end

	assign rdata_o        = st.rdata;
	assign divider_sync_o = st.div_sync;
	assign lmfc_o         = st.lmfc;
	assign ctrl_bits_o    = st.ctrl;
	assign subclass_o     = st.subclass[sref_pkg::SUBCLASS_BIT];
endmodule // sref_capture
`default_nettype wire

// ===== tb/sref_src.sv
/*
 * sref_src: reference pulse source standing on the far side of the pin.
 * Assumes fire_i is a one-cycle strobe from the bench; the line idles low.
 */
`timescale 1ns/1ps
`default_nettype none
module sref_src (
	input  wire logic       clk_i,
	input  wire logic       fire_i,
	input  wire logic [4:0] width_i,
	output logic            sysref_o
);
	logic [4:0] left = 5'h00;

	// never shorter than two clocks, so the divider-by-one minimum is kept
	always_ff @(posedge clk_i)
	begin
		if (fire_i)
			left <= (width_i < 5'h02) ? 5'h02 : width_i;
		else if (left != 5'h00)
			left <= left - 5'h01;
	end

	// periodic spacing is the caller's job, in whole multiframes
	assign sysref_o = (left != 5'h00);
endmodule // sref_src
`default_nettype wire

// ===== tb/sref_capture_monitor.sv
/*
 * sref_capture_monitor: port checks for sref_capture.
 * Assumes ce_i stays high; bound below by the bind statement.
 */
`timescale 1ns/1ps
`default_nettype none
module sref_capture_monitor (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        ce_i,
	input wire logic [11:0] addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic        sysref_i,
	input wire logic        decimation_ratio_mode_i,
	input wire logic [7:0]  rdata_o,
	input wire logic        divider_sync_o,
	input wire logic        lmfc_o,
	input wire logic [2:0]  ctrl_bits_o,
	input wire logic        subclass_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	logic [1:0] cs_q;
	logic       mapped;

	// shadow of the control-bit count, needed to judge which bits may fire
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			cs_q <= 2'h0;
		else if (wr_i && addr_i == 12'h058f)
			cs_q <= wdata_i[7:6];
	end
	assign mapped = addr_i inside {12'h010b, 12'h0120, 12'h0121, 12'h0122, 12'h0123, 12'h0128, 12'h0129,
		12'h0130, 12'h01ff, 12'h0559, 12'h055a, 12'h058f, 12'h0590};

	sequence unmapped_rd;
		rd_i && !mapped;
	endsequence
	sequence sub_wr;
		wr_i && addr_i == 12'h0590;
	endsequence
	sequence tag_seen;
		ctrl_bits_o != 3'h0;
	endsequence

	rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	unmapped_read_a: assert property (unmapped_rd |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	sync_pulse_a: assert property (divider_sync_o |=> !divider_sync_o)
		else $error("sync pulse too long");
	sync_frame_a: assert property (divider_sync_o |-> lmfc_o)
		else $error("sync without frame phase zero");
	tag_pulse_a: assert property (tag_seen |=> ctrl_bits_o == 3'h0)
		else $error("tag longer than one sample");
	tag_no_sync_a: assert property (tag_seen |-> !divider_sync_o)
		else $error("tag with divider realign");
	tag_count_a: assert property (tag_seen |-> cs_q != 2'h0)
		else $error("tag with zero control bits");
	tag_order_a: assert property ((ctrl_bits_o[1] |-> cs_q >= 2'h2) and (ctrl_bits_o[0] |-> cs_q == 2'h3))
		else $error("control bit used out of order");
	tag_decim_a: assert property (decimation_ratio_mode_i && $past(decimation_ratio_mode_i) |-> !ctrl_bits_o)
		else $error("tag during decimation");
	subclass_wr_a: assert property (sub_wr |-> ##2 subclass_o == $past(wdata_i[5], 2))
		else $error("subclass output not following write");
endmodule // sref_capture_monitor

bind sref_capture sref_capture_monitor sref_capture_monitor_i (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .sysref_i(sysref_i),
	.decimation_ratio_mode_i(decimation_ratio_mode_i), .rdata_o(rdata_o), .divider_sync_o(divider_sync_o),
	.lmfc_o(lmfc_o), .ctrl_bits_o(ctrl_bits_o), .subclass_o(subclass_o));
`default_nettype wire

// ===== tb/tb.sv
/*
 * tb: register and reference-pulse tests for sref_capture.
 * Assumes the sref_src source model; ce_i tied high throughout.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [11:0] addr_i = 12'h000;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        dec = 1'b0;
	logic        fire = 1'b0;
	logic [4:0]  width = 5'h02;
	logic        sysref;
	logic [7:0]  rdata;
	logic        dsync;
	logic        lmfc;
	logic [2:0]  cbits;
	logic        sub;
	logic [2:0]  tag_v = 3'h0;
	logic [7:0]  v;
	int          bad_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          syncs = 0;
	int          tags = 0;
	int          tag_at = 0;
	int          n;
	int          m;
	int          t;
	int          lat [4];
	logic [11:0] ra [8] = '{12'h01ff, 12'h0120, 12'h0122, 12'h0123, 12'h0559, 12'h055a, 12'h058f, 12'h0590};
	logic [7:0]  re [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
	logic [7:0]  cfg [4] = '{8'h04, 8'h0c, 8'h14, 8'h1c};
	logic [7:0]  cs [4] = '{8'h40, 8'h80, 8'hc0, 8'h40};
	logic [7:0]  lo [4] = '{8'h00, 8'h50, 8'h05, 8'h00};
	logic [7:0]  hi [4] = '{8'h05, 8'h00, 8'h00, 8'h05};
	logic [7:0]  dl [4] = '{8'h00, 8'h00, 8'h00, 8'h03};
	logic [7:0]  ex [4] = '{8'h04, 8'h02, 8'h01, 8'h04};

	initial
	begin
		forever #20 clk_i = ~clk_i;
	end

	sref_capture sref_capture_i (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .sysref_i(sysref), .decimation_ratio_mode_i(dec), .rdata_o(rdata),
		.divider_sync_o(dsync), .lmfc_o(lmfc), .ctrl_bits_o(cbits), .subclass_o(sub));
	sref_src sref_src_i (.clk_i(clk_i), .fire_i(fire), .width_i(width), .sysref_o(sysref));

	task automatic test_done();
		if (bad_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// event counters; the run is cut short well past the expected length
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (dsync === 1'b1)
			syncs <= syncs + 1;
		if (cbits !== 3'h0)
		begin
			tags <= tags + 1;
			tag_v <= cbits;
			tag_at <= cyc;
		end
		if (cyc == 6000)
		begin
			bad_count = bad_count + 1;
			test_done();
		end
	end

	task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe is taken
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk($sformatf("reg %h", a), rdata, e);
	endtask

	task automatic pulse(input logic [4:0] w);
		@(posedge clk_i);
		width <= w;
		fire <= 1'b1;
		@(posedge clk_i);
		fire <= 1'b0;
	endtask

	task automatic at(input int c);
		while (cyc < c)
			@(posedge clk_i);
		pulse(5'h02);
	endtask

	initial
	begin
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		#1 chk("subclass", {7'h00, sub}, 8'h01);
		chk("outputs", {3'h0, lmfc, cbits, dsync}, 8'h00);
		foreach (ra[i]) rc(ra[i], re[i]);
		wr(12'h0122, 8'h09);
		rc(12'h0122, 8'h09);
		wr(12'h0122, 8'h00);
		@(posedge clk_i);
		addr_i <= 12'h0128;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata;
		wr(12'h0128, ~v);
		rc(12'h0128, v);
		rc(12'h0200, 8'h00);
		pulse(5'h04);
		repeat (12) @(posedge clk_i);
		chk("idle syncs", syncs[7:0], 8'h00);
		// capture polarity and edge; falling transition waits for the pulse end
		foreach (cfg[i])
		begin
			wr(12'h0120, cfg[i]);
			n = syncs;
			pulse(5'h0c);
			repeat (8) @(posedge clk_i);
			chk("early sync", 8'(syncs - n), {7'h00, ~cfg[i][4]});
			repeat (12) @(posedge clk_i);
			chk("late sync", 8'(syncs - n), 8'h01);
			rc(12'h0120, cfg[i] & 8'hf9);
		end
		pulse(5'h04);
		repeat (12) @(posedge clk_i);
		chk("disarmed", syncs[7:0], 8'h04);
		// ignore two events; a rewrite of the mode reloads the count
		wr(12'h0121, 8'h02);
		wr(12'h0120, 8'h04);
		n = syncs;
		pulse(5'h02);
		repeat (10) @(posedge clk_i);
		wr(12'h0120, 8'h04);
		repeat (2)
		begin
			pulse(5'h02);
			repeat (10) @(posedge clk_i);
		end
		chk("reloaded", 8'(syncs - n), 8'h00);
		pulse(5'h02);
		repeat (10) @(posedge clk_i);
		chk("nshot", 8'(syncs - n), 8'h01);
		wr(12'h0121, 8'h00);
		// continuous: multiframe is 32 clocks; one clock late or early
		wr(12'h0120, 8'h02);
		t = cyc + 8;
		at(t);
		repeat (10) @(posedge clk_i);
		n = syncs;
		at(t + 64);
		repeat (10) @(posedge clk_i);
		chk("aligned", 8'(syncs - n), 8'h00);
		at(t + 129);
		repeat (10) @(posedge clk_i);
		chk("late resync", 8'(syncs - n), 8'h01);
		wr(12'h0122, 8'h01);
		at(t + 194);
		repeat (10) @(posedge clk_i);
		wr(12'h0122, 8'h04);
		at(t + 256);
		repeat (10) @(posedge clk_i);
		chk("in window", 8'(syncs - n), 8'h01);
		wr(12'h0120, 8'h00);
		wr(12'h0122, 8'h00);
		// timestamp: each control-bit layout, then a delayed tag
		wr(12'h01ff, 8'h01);
		n = syncs;
		foreach (cs[i])
		begin
			wr(12'h058f, cs[i]);
			wr(12'h0559, lo[i]);
			wr(12'h055a, hi[i]);
			wr(12'h0123, dl[i]);
			wr(12'h0120, 8'h04);
			m = tags;
			t = cyc;
			pulse(5'h02);
			repeat (16) @(posedge clk_i);
			lat[i] = tag_at - t;
			chk("tag bits", {5'h00, tag_v}, ex[i]);
			chk("tag count", 8'(tags - m), 8'h01);
		end
		chk("tag delay", 8'(lat[3] - lat[0]), 8'h03);
		chk("no realign", 8'(syncs - n), 8'h00);
		m = tags;
		pulse(5'h02);
		repeat (16) @(posedge clk_i);
		chk("mode off", 8'(tags - m), 8'h00);
		dec <= 1'b1;
		wr(12'h0120, 8'h04);
		pulse(5'h02);
		repeat (16) @(posedge clk_i);
		chk("decimation", 8'(tags - m), 8'h00);
		dec <= 1'b0;
		wr(12'h0590, 8'h00);
		repeat (3) @(posedge clk_i);
		#1 chk("subclass off", {7'h00, sub}, 8'h00);
		test_done();
	end
endmodule // tb
`default_nettype wire
